//--- p1lc_pkg.sv
// What this block does
// R1: Switch-side loopback returns switch transmit frames to switch receive, none reach MAC.
// R2: Software sets receive-own-transmit elsewhere when using switch loopback in half duplex.
// R3: Switch loopback works under isolate; both loopbacks only in MII/RMII PHY modes.
// R4: In MII MAC mode with manual duplex set, duplex follows the duplex bit.
// R5: In MII MAC mode without manual duplex, duplex comes from pin and polarity strap.
// R6: Turbo bit makes speed select choose 200 or 10, else 100 or 10 Mbps.
// R7: Speed select sets PHY-mode speed: 0 is 10 Mbps, 1 the higher rate.
// R8: Bits 25:24 report port mode: MII MAC, MII PHY, RMII PHY, internal PHY.
// R9: Switch collision test asserts switch collision while the switch transmits, PHY modes.
// R10: Software uses the switch collision test only while a loopback is active.
// R11: Bit 22 makes the reference clock pin an input (0) or output (1).
// R12: Bit 21 picks 12 or 16 mA for RMII and 200 Mbps; else 12 mA.
// R13: Bit 16 disables the heartbeat test, in MII PHY mode only.
// R14: MAC-side loopback returns MAC transmit frames to the MAC, none reach the switch.
// R15: Isolate in PHY mode stops output drive, disables pulls, ignores MII inputs.
// R16: Bit 8 sets duplex in PHY modes and in MAC mode with manual duplex.
// R17: Configuration loader overwrites the whole register after reset and each reload.
// R18: Reserved bits read zero, ignore writes; strap fields reset from latched straps.
package p1lc_pkg;
  localparam logic [11:0] P1LC_LINK_CTRL_OFFSET = 12'h1ec;
  localparam int P1LC_SW_LOOP_BIT = 30;
  localparam int P1LC_MAN_DUPLEX_BIT = 28;
  localparam int P1LC_TURBO_BIT = 26;
  localparam int P1LC_MODE_LSB = 24;
  localparam int P1LC_SW_COL_BIT = 23;
  localparam int P1LC_CLK_DIR_BIT = 22;
  localparam int P1LC_CLK_STR_BIT = 21;
  localparam int P1LC_SQE_OFF_BIT = 16;
  localparam int P1LC_MAC_LOOP_BIT = 14;
  localparam int P1LC_SPEED_BIT = 13;
  localparam int P1LC_ISOLATE_BIT = 10;
  localparam int P1LC_DUPLEX_BIT = 8;
  localparam int P1LC_MAC_COL_BIT = 7;
  // Software-writable bits; mode is read-only to software
  localparam logic [31:0] P1LC_SW_MASK = 32'h54e16580;
  // Loader may also rewrite the strapped mode field
  localparam logic [31:0] P1LC_LOAD_MASK = 32'h57e16580;
  localparam logic [31:0] P1LC_RESET_VALUE = 32'h00000000;
  localparam logic [1:0] P1LC_MODE_MII_MAC = 2'h0;
  localparam logic [1:0] P1LC_MODE_MII_PHY = 2'h1;
  localparam logic [1:0] P1LC_MODE_RMII_PHY = 2'h2;
  localparam logic [1:0] P1LC_MODE_INT_PHY = 2'h3;
  localparam logic [1:0] P1LC_SPEED_10 = 2'h0;
  localparam logic [1:0] P1LC_SPEED_100 = 2'h1;
  localparam logic [1:0] P1LC_SPEED_200 = 2'h2;
  // Cycles after reset release before straps are taken (one more than the two-stage synchroniser depth)
  localparam logic [1:0] P1LC_STRAP_WAIT = 2'h3;
  typedef enum logic [2:0] {
    P1LC_ST_WAIT = 3'b001,
    P1LC_ST_CAPTURE = 3'b010,
    P1LC_ST_RUN = 3'b100
  } p1lc_state_e;
endpackage : p1lc_pkg

//--- p1lc_sync.sv
`timescale 1ns/1ps
module p1lc_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Asynchronous level in, synchronised level out
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;

  // First stage feeds only the second stage
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule : p1lc_sync

//--- p1lc_port1_link_control.sv
// The plain strobed port was decided locally.
`timescale 1ns/1ps
module p1lc_port1_link_control (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Configuration loader
  input wire logic loader_wr,
  input wire logic [31:0] loader_data,
  // Straps
  input wire logic [1:0] strap_mode,
  input wire logic strap_turbo,
  input wire logic strap_clk_dir,
  input wire logic strap_clk_strength,
  input wire logic strap_sqe_off,
  input wire logic strap_speed,
  input wire logic strap_duplex_pol,
  // External MAC or PHY pins
  input wire logic port1_duplex_input,
  input wire logic mac_tx_en_in,
  input wire logic [3:0] mac_txd_in,
  output logic mac_rx_dv_out,
  output logic [3:0] mac_rxd_out,
  output logic mac_col_out,
  output logic mii_out_oe,
  output logic mii_pull_en,
  input wire logic port1_reference_clock_pin_in,
  output logic port1_reference_clock_pin_out,
  output logic port1_reference_clock_pin_oe,
  output logic ref_clk_in_level,
  // Switch fabric side
  input wire logic sw_tx_en,
  input wire logic [3:0] sw_txd,
  output logic sw_rx_dv,
  output logic [3:0] sw_rxd,
  output logic sw_col,
  // Port configuration
  output logic duplex_full,
  output logic [1:0] speed_sel,
  output logic clk_strength_16ma,
  output logic heartbeat_test_enable,
  output logic straps_ready
);
  logic [1:0] mode_s;
  logic [5:0] strap_s;
  logic duplex_pin_s;
  logic mac_tx_en_s;
  logic [3:0] mac_txd_s;
  logic refclk_s;
  logic [31:0] ctrl_reg;
  logic [31:0] ctrl_next;
  p1lc_pkg::p1lc_state_e state_reg;
  logic [1:0] wait_reg;
  logic duplex_pol_reg;
  logic [1:0] mode;
  logic phy_mode;
  logic mii_phy;
  logic isolate_act;
  logic sw_loop;
  logic mac_loop;
  logic mac_tx_en_eff;
  logic [3:0] mac_txd_eff;

  // Every pin and strap is synchronised before use
  p1lc_sync #(.WIDTH(15)) u_sync (
    .clk(clk),
    .rst(rst),
    .async_in({strap_mode, strap_turbo, strap_clk_dir, strap_clk_strength, strap_sqe_off,
               strap_speed, strap_duplex_pol, port1_duplex_input, mac_tx_en_in, mac_txd_in,
               port1_reference_clock_pin_in}),
    .sync_out({mode_s, strap_s, duplex_pin_s, mac_tx_en_s, mac_txd_s, refclk_s})
  );

  function automatic logic [31:0] strap_word(input logic [1:0] m, input logic [5:0] s,
                                             input logic dpin);
    logic [31:0] w;
    w = p1lc_pkg::P1LC_RESET_VALUE;
    w[p1lc_pkg::P1LC_MODE_LSB +: 2] = m;
    w[p1lc_pkg::P1LC_TURBO_BIT] = s[5];
    w[p1lc_pkg::P1LC_CLK_DIR_BIT] = s[4];
    w[p1lc_pkg::P1LC_CLK_STR_BIT] = s[3];
    w[p1lc_pkg::P1LC_SQE_OFF_BIT] = s[2];
    w[p1lc_pkg::P1LC_SPEED_BIT] = s[1];
    w[p1lc_pkg::P1LC_DUPLEX_BIT] = (dpin == s[0]);
    return w;
  endfunction : strap_word

  // Straps are caught after release, never under the reset itself
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= p1lc_pkg::P1LC_ST_WAIT;
      wait_reg <= 2'h0;
    end else begin
      unique case (state_reg)
        p1lc_pkg::P1LC_ST_WAIT: begin
          wait_reg <= wait_reg + 2'h1;
          if (wait_reg == p1lc_pkg::P1LC_STRAP_WAIT - 2'h1) begin
            state_reg <= p1lc_pkg::P1LC_ST_CAPTURE;
          end
        end
        p1lc_pkg::P1LC_ST_CAPTURE: begin
          state_reg <= p1lc_pkg::P1LC_ST_RUN;
        end
        p1lc_pkg::P1LC_ST_RUN: begin
          state_reg <= p1lc_pkg::P1LC_ST_RUN;
        end
        default: begin
          state_reg <= p1lc_pkg::P1LC_ST_WAIT;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      duplex_pol_reg <= 1'b0;
    end else if (state_reg == p1lc_pkg::P1LC_ST_CAPTURE) begin
      duplex_pol_reg <= strap_s[0];
    end
  end

  // Loader beats software when both write in one cycle in the run state; before run the loader write is dropped
  always_comb begin
    ctrl_next = ctrl_reg;
    if (state_reg == p1lc_pkg::P1LC_ST_CAPTURE) begin
      ctrl_next = strap_word(mode_s, strap_s, duplex_pin_s); // [R18]
    end else if (loader_wr && state_reg == p1lc_pkg::P1LC_ST_RUN) begin
      ctrl_next = loader_data & p1lc_pkg::P1LC_LOAD_MASK; // [R17]
    end else if (reg_wr && reg_addr == p1lc_pkg::P1LC_LINK_CTRL_OFFSET) begin
      ctrl_next = (ctrl_reg & ~p1lc_pkg::P1LC_SW_MASK) |
                  (reg_wdata & p1lc_pkg::P1LC_SW_MASK); // [R18]
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_reg <= p1lc_pkg::P1LC_RESET_VALUE;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  // Unmapped reads return zero; data stands one cycle only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd && reg_addr == p1lc_pkg::P1LC_LINK_CTRL_OFFSET) begin
      reg_rdata <= ctrl_reg; // [R8]
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

  assign mode = ctrl_reg[p1lc_pkg::P1LC_MODE_LSB +: 2];
  assign mii_phy = (mode == p1lc_pkg::P1LC_MODE_MII_PHY);
  assign phy_mode = mii_phy || (mode == p1lc_pkg::P1LC_MODE_RMII_PHY);
  assign isolate_act = phy_mode && ctrl_reg[p1lc_pkg::P1LC_ISOLATE_BIT]; // [R15]
  // Switch loopback ignores isolate on purpose
  assign sw_loop = phy_mode && ctrl_reg[p1lc_pkg::P1LC_SW_LOOP_BIT]; // [R3]
  assign mac_loop = phy_mode && ctrl_reg[p1lc_pkg::P1LC_MAC_LOOP_BIT]; // [R3]
  assign mac_tx_en_eff = mac_tx_en_s && !isolate_act; // [R15]
  assign mac_txd_eff = isolate_act ? 4'h0 : mac_txd_s; // [R15]

  // Receive path toward the switch engine
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sw_rx_dv <= 1'b0;
      sw_rxd <= 4'h0;
    end else if (sw_loop) begin
      sw_rx_dv <= sw_tx_en; // [R1]
      sw_rxd <= sw_txd; // [R1]
    end else if (mac_loop) begin
      sw_rx_dv <= 1'b0; // [R14]
      sw_rxd <= 4'h0;
    end else begin
      sw_rx_dv <= mac_tx_en_eff;
      sw_rxd <= mac_txd_eff;
    end
  end

  // Receive path toward the external MAC
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mac_rx_dv_out <= 1'b0;
      mac_rxd_out <= 4'h0;
    end else if (mac_loop) begin
      mac_rx_dv_out <= mac_tx_en_eff; // [R14]
      mac_rxd_out <= mac_txd_eff; // [R14]
    end else if (sw_loop) begin
      mac_rx_dv_out <= 1'b0; // [R1]
      mac_rxd_out <= 4'h0;
    end else begin
      mac_rx_dv_out <= sw_tx_en;
      mac_rxd_out <= sw_txd;
    end
  end

  // Collision tests; only meaningful alongside a loopback
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sw_col <= 1'b0;
      mac_col_out <= 1'b0;
    end else begin
      sw_col <= phy_mode && ctrl_reg[p1lc_pkg::P1LC_SW_COL_BIT] && sw_tx_en; // [R9]
      mac_col_out <= mii_phy && ctrl_reg[p1lc_pkg::P1LC_MAC_COL_BIT] && mac_tx_en_eff;
    end
  end

  // Pin drive controls
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mii_out_oe <= 1'b0;
      mii_pull_en <= 1'b0;
      port1_reference_clock_pin_oe <= 1'b0;
      port1_reference_clock_pin_out <= 1'b0;
      ref_clk_in_level <= 1'b0;
    end else begin
      mii_out_oe <= !isolate_act; // [R15]
      mii_pull_en <= !isolate_act; // [R15]
      port1_reference_clock_pin_oe <= ctrl_reg[p1lc_pkg::P1LC_CLK_DIR_BIT]; // [R11]
      // Divided reference only toggles while the pin is an output
      port1_reference_clock_pin_out <= ctrl_reg[p1lc_pkg::P1LC_CLK_DIR_BIT] &&
                                       !port1_reference_clock_pin_out;
      ref_clk_in_level <= refclk_s;
    end
  end

  // Duplex selection
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      duplex_full <= 1'b0;
    end else if (mode == p1lc_pkg::P1LC_MODE_MII_MAC &&
                 !ctrl_reg[p1lc_pkg::P1LC_MAN_DUPLEX_BIT]) begin
      duplex_full <= (duplex_pin_s == duplex_pol_reg); // [R5]
    end else begin
      duplex_full <= ctrl_reg[p1lc_pkg::P1LC_DUPLEX_BIT]; // [R4] [R16]
    end
  end

  // Speed, drive strength and heartbeat test
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      speed_sel <= p1lc_pkg::P1LC_SPEED_10;
      clk_strength_16ma <= 1'b0;
      heartbeat_test_enable <= 1'b0;
    end else begin
      if (!phy_mode) begin
        speed_sel <= p1lc_pkg::P1LC_SPEED_100;
      end else if (!ctrl_reg[p1lc_pkg::P1LC_SPEED_BIT]) begin
        speed_sel <= p1lc_pkg::P1LC_SPEED_10; // [R7]
      end else if (ctrl_reg[p1lc_pkg::P1LC_TURBO_BIT]) begin
        speed_sel <= p1lc_pkg::P1LC_SPEED_200; // [R6]
      end else begin
        speed_sel <= p1lc_pkg::P1LC_SPEED_100; // [R6]
      end
      clk_strength_16ma <= ctrl_reg[p1lc_pkg::P1LC_CLK_STR_BIT] &&
                           ((mode == p1lc_pkg::P1LC_MODE_RMII_PHY) ||
                            (mii_phy && ctrl_reg[p1lc_pkg::P1LC_TURBO_BIT] &&
                             ctrl_reg[p1lc_pkg::P1LC_SPEED_BIT])); // [R12]
      heartbeat_test_enable <= mii_phy && !ctrl_reg[p1lc_pkg::P1LC_SQE_OFF_BIT]; // [R13]
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      straps_ready <= 1'b0;
    end else begin
      straps_ready <= (state_reg == p1lc_pkg::P1LC_ST_RUN);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_switch_loop_path: assert property (sw_loop && !mac_loop && $stable(sw_loop) |=> // [R1]
    sw_rx_dv == $past(sw_tx_en) && !mac_rx_dv_out)
    else $error("Switch loopback path wrong");
  a_mac_loop_path: assert property (mac_loop && !sw_loop |=> // [R14]
    mac_rx_dv_out == $past(mac_tx_en_eff) && !sw_rx_dv)
    else $error("MAC loopback path wrong");
  a_loop_under_iso: assert property (sw_loop && isolate_act && sw_tx_en |=> sw_rx_dv) // [R3]
    else $error("Switch loopback lost under isolate");
  a_mac_duplex_pin: assert property (mode == p1lc_pkg::P1LC_MODE_MII_MAC && // [R5]
    !ctrl_reg[p1lc_pkg::P1LC_MAN_DUPLEX_BIT] && $stable(ctrl_reg) |=>
    duplex_full == ($past(duplex_pin_s) == $past(duplex_pol_reg)))
    else $error("Pin duplex wrong");
  a_manual_duplex: assert property (ctrl_reg[p1lc_pkg::P1LC_MAN_DUPLEX_BIT] |=> // [R4]
    duplex_full == $past(ctrl_reg[p1lc_pkg::P1LC_DUPLEX_BIT]))
    else $error("Manual duplex wrong");
  a_speed_turbo: assert property (phy_mode && ctrl_reg[p1lc_pkg::P1LC_SPEED_BIT] && // [R6]
    ctrl_reg[p1lc_pkg::P1LC_TURBO_BIT] |=> speed_sel == p1lc_pkg::P1LC_SPEED_200)
    else $error("Turbo speed wrong");
  a_speed_ten: assert property (phy_mode && !ctrl_reg[p1lc_pkg::P1LC_SPEED_BIT] |=> // [R7]
    speed_sel == p1lc_pkg::P1LC_SPEED_10)
    else $error("Ten megabit speed wrong");
  a_mode_readback: assert property (reg_rd && reg_addr == p1lc_pkg::P1LC_LINK_CTRL_OFFSET |=> // [R8]
    reg_rdata[p1lc_pkg::P1LC_MODE_LSB +: 2] == $past(mode))
    else $error("Mode readback wrong");
  a_sw_col_test: assert property (phy_mode && ctrl_reg[p1lc_pkg::P1LC_SW_COL_BIT] && // [R9]
    sw_tx_en |=> sw_col)
    else $error("Switch collision missing");
  a_clk_dir: assert property (##1 port1_reference_clock_pin_oe == // [R11]
    $past(ctrl_reg[p1lc_pkg::P1LC_CLK_DIR_BIT]))
    else $error("Clock direction wrong");
  a_strength_slow: assert property (mii_phy && !ctrl_reg[p1lc_pkg::P1LC_TURBO_BIT] |=> // [R12]
    !clk_strength_16ma)
    else $error("Drive strength not 12 mA");
  a_heartbeat_mode: assert property (!mii_phy |=> !heartbeat_test_enable) // [R13]
    else $error("Heartbeat outside MII PHY");
  a_isolate_drive: assert property (isolate_act |=> !mii_out_oe && !mii_pull_en) // [R15]
    else $error("Isolate still drives");
  a_loader_write: assert property (loader_wr && state_reg == p1lc_pkg::P1LC_ST_RUN |=> // [R17]
    ctrl_reg == ($past(loader_data) & p1lc_pkg::P1LC_LOAD_MASK))
    else $error("Loader write lost");
  a_reserved_zero: assert property ((ctrl_reg & ~p1lc_pkg::P1LC_LOAD_MASK) == 32'h00000000) // [R18]
    else $error("Reserved bit set");

  c_switch_loop: cover property (sw_loop && sw_tx_en ##1 sw_rx_dv);
  c_mac_loop: cover property (mac_loop && mac_tx_en_eff ##1 mac_rx_dv_out);
  c_turbo: cover property (speed_sel == p1lc_pkg::P1LC_SPEED_200 && clk_strength_16ma);
  c_loader: cover property (loader_wr && state_reg == p1lc_pkg::P1LC_ST_RUN);
endmodule : p1lc_port1_link_control

//--- p1lc_mac_model.sv
`timescale 1ns/1ps
module p1lc_mac_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Commands from the bench
  input wire logic send,
  input wire logic [3:0] nib,
  input wire logic dup_lvl,
  // Pins toward the port
  output logic tx_en,
  output logic [3:0] txd,
  output logic duplex_pin,
  output logic ref_drv
);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_en <= 1'b0;
      txd <= 4'h0;
    end else begin
      tx_en <= send;
      // Idle data lines keep changing so a stale nibble never looks valid
      txd <= send ? nib : ~txd;
    end
  end

  // Far-side reference clock runs free
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ref_drv <= 1'b0;
    end else begin
      ref_drv <= ~ref_drv;
    end
  end

  assign duplex_pin = dup_lvl;
endmodule : p1lc_mac_model

//--- tb_top.sv
`timescale 1ns/1ps
module tb_top;
  localparam logic [11:0] A = p1lc_pkg::P1LC_LINK_CTRL_OFFSET;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [11:0] reg_addr = 12'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic loader_wr = 1'b0;
  logic [31:0] loader_data = 32'h0;
  // Mode MII PHY, turbo, dir in, 16 mA, test on, fast, polarity low
  logic [7:0] straps = 8'h6a;
  logic sw_tx_en = 1'b0;
  logic [3:0] sw_txd = 4'h0;
  logic send = 1'b0;
  logic [3:0] nib = 4'ha;
  logic dup_lvl = 1'b0;
  logic [31:0] reg_rdata;
  logic [3:0] mac_txd, mac_rxd, sw_rxd;
  logic [1:0] speed_sel;
  logic mac_tx_en, dup_pin, ref_drv, ref_out, ref_oe, ref_lvl, mac_rx_dv, mac_col;
  logic oe, pull, sw_rx_dv, sw_col, duplex_full, str16, hb, ready;
  int err_total = 0;
  int samples_checked = 0;
  wire ref_pin = ref_oe ? ref_out : ref_drv;
  wire [5:0] cfgv = {ref_oe, duplex_full, speed_sel, str16, hb};
  wire [13:0] pathv = {sw_rx_dv, sw_rxd, mac_rx_dv, mac_rxd, sw_col, mac_col, oe, pull};

  always #25 clk = ~clk;

  p1lc_mac_model mac_u (.clk(clk), .rst(rst), .send(send), .nib(nib), .dup_lvl(dup_lvl),
    .tx_en(mac_tx_en), .txd(mac_txd), .duplex_pin(dup_pin), .ref_drv(ref_drv));

  p1lc_port1_link_control dut_u (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .loader_wr(loader_wr), .loader_data(loader_data), .strap_mode(straps[7:6]),
    .strap_turbo(straps[5]), .strap_clk_dir(straps[4]), .strap_clk_strength(straps[3]),
    .strap_sqe_off(straps[2]), .strap_speed(straps[1]), .strap_duplex_pol(straps[0]),
    .port1_duplex_input(dup_pin), .mac_tx_en_in(mac_tx_en), .mac_txd_in(mac_txd),
    .mac_rx_dv_out(mac_rx_dv), .mac_rxd_out(mac_rxd), .mac_col_out(mac_col),
    .mii_out_oe(oe), .mii_pull_en(pull), .port1_reference_clock_pin_in(ref_pin),
    .port1_reference_clock_pin_out(ref_out), .port1_reference_clock_pin_oe(ref_oe),
    .ref_clk_in_level(ref_lvl), .sw_tx_en(sw_tx_en), .sw_txd(sw_txd),
    .sw_rx_dv(sw_rx_dv), .sw_rxd(sw_rxd), .sw_col(sw_col), .duplex_full(duplex_full),
    .speed_sel(speed_sel), .clk_strength_16ma(str16), .heartbeat_test_enable(hb),
    .straps_ready(ready));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask : rd

  // Writes by software or by the loader, then checks the port setup
  task automatic setc(input logic ld, input logic [31:0] v, input logic [5:0] e);
    if (ld) begin
      @(posedge clk);
      loader_wr <= 1'b1;
      loader_data <= v;
      @(posedge clk);
      loader_wr <= 1'b0;
    end else begin
      wr(A, v);
    end
    step(2);
    chk(cfgv, e);
  endtask : setc

  // Both sides send at once; held long enough to clear the pin synchronisers
  task automatic xfer(input logic [13:0] e);
    @(posedge clk);
    sw_tx_en <= 1'b1;
    sw_txd <= 4'h5;
    send <= 1'b1;
    step(5);
    chk(pathv, e);
    @(posedge clk);
    sw_tx_en <= 1'b0;
    send <= 1'b0;
    step(5);
  endtask : xfer

  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (4000) @(posedge clk);
    err_total++;
    tally_and_finish();
  end

  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 40 && ready !== 1'b1; i++) @(posedge clk);
    #1;
    chk(ready, 1'b1);
    rd(A, 32'h05202100);
    chk(cfgv, {1'b0, 1'b1, 2'h2, 1'b1, 1'b1});
    // Pin is an input: level seen three edges late from a toggling source
    chk(ref_lvl ^ ref_drv, 1'b1);
    wr(A, 32'hffffffff);
    rd(A, 32'h55e16580);
    wr(12'h1f0, 32'h0);
    rd(A, 32'h55e16580);
    rd(12'h1f0, 32'h0);
    setc(1'b0, 32'h04002100, {1'b0, 1'b1, 2'h2, 1'b0, 1'b1});
    setc(1'b0, 32'h04602000, {1'b1, 1'b0, 2'h2, 1'b1, 1'b1});
    step(2);
    // Pin is an output: own toggling clock comes back on the input side
    chk(ref_lvl ^ ref_out, 1'b1);
    setc(1'b0, 32'h00212100, {1'b0, 1'b1, 2'h1, 1'b0, 1'b0});
    setc(1'b0, 32'h00000000, {1'b0, 1'b0, 2'h0, 1'b0, 1'b1});
    setc(1'b0, 32'h00000100, {1'b0, 1'b1, 2'h0, 1'b0, 1'b1});
    xfer({1'b1, 4'ha, 1'b1, 4'h5, 1'b0, 1'b0, 1'b1, 1'b1});
    // Full duplex, so receive-own-transmit in mac_receive_config is not needed
    wr(A, 32'h40800500);
    xfer({1'b1, 4'h5, 1'b0, 4'h0, 1'b1, 1'b0, 1'b0, 1'b0});
    wr(A, 32'h00004080);
    xfer({1'b0, 4'h0, 1'b1, 4'ha, 1'b0, 1'b1, 1'b1, 1'b1});
    wr(A, 32'h00004480);
    xfer({1'b0, 4'h0, 1'b0, 4'h0, 1'b0, 1'b0, 1'b0, 1'b0});
    @(posedge clk);
    dup_lvl <= 1'b1;
    setc(1'b1, 32'h10000100, {1'b0, 1'b1, 2'h1, 1'b0, 1'b0});
    rd(A, 32'h10000100);
    setc(1'b1, 32'h00000100, {1'b0, 1'b0, 2'h1, 1'b0, 1'b0});
    @(posedge clk);
    dup_lvl <= 1'b0;
    step(4);
    chk(cfgv, {1'b0, 1'b1, 2'h1, 1'b0, 1'b0});
    setc(1'b1, 32'h40800400, {1'b0, 1'b1, 2'h1, 1'b0, 1'b0});
    xfer({1'b1, 4'ha, 1'b1, 4'h5, 1'b0, 1'b0, 1'b1, 1'b1});
    setc(1'b1, 32'hffffffff, {1'b1, 1'b1, 2'h1, 1'b0, 1'b0});
    rd(A, 32'h57e16580);
    tally_and_finish();
  end
endmodule : tb_top
